/* spa_codec.sv */
// serial codec model on the far side of the link
`timescale 1ns/1ps
module spa_codec
(
   output logic      link_sck,
   output logic      link_ws,
   output logic      link_sdi,
   input  wire logic link_sdo
);
   logic [15:0] rx_word;
   // link idles with clock still
   initial
   begin
      link_sck = 1'b0;
      link_ws = 1'b0;
      link_sdi = 1'b0;
   end
   // first n bits of a word, msb first, 400 ns bit clock, ws high first half
   task automatic xfer(input logic [15:0] w, input int n = 16);
      for (int i = 15; i > 15 - n; i--)
      begin
         link_sdi = w[i];
         link_ws = (i > 15 - n / 2);
         #200;
         rx_word[i] = link_sdo;
         link_sck = 1'b1;
         #200;
         link_sck = 1'b0;
      end
      link_sdi = ~w[16 - n]; // released line shows no stale bit
      #400;
   endtask
endmodule // spa_codec

/* spa_map.svh */
// register offsets, field positions and reset values of the audio port
`ifndef SPA_MAP_SVH
`define SPA_MAP_SVH

// register byte offsets
`define SPA_OFS_CTRL      8'h00
`define SPA_OFS_CON2      8'h04
`define SPA_OFS_STAT      8'h08
`define SPA_OFS_MASK      8'h0c
`define SPA_OFS_TXB       8'h10
`define SPA_OFS_RXB       8'h14

// port control register
`define SPA_ON_BIT        15
`define SPA_CTRL_WMASK    32'h0000_8000
`define SPA_CTRL_RST      32'h0000_0000

// second control register fields
`define SPA_SGNEXT_BIT    15
`define SPA_FRMEN_BIT     12
`define SPA_ROVEN_BIT     11
`define SPA_TUREN_BIT     10
`define SPA_OVERFLOW_NONCRITICAL_BIT    9
`define SPA_UNDERRUN_NONCRITICAL_BIT    8
`define SPA_AUDIO_PROTOCOL_EN_BIT     7
`define SPA_MONO_BIT      3
`define SPA_MOD_HI        1
`define SPA_MOD_LO        0
`define SPA_CON2_WMASK    32'h0000_9f8b
`define SPA_CON2_AUDMASK  32'h0000_008b
`define SPA_CON2_RST      32'h0000_0000

// status register fields
`define SPA_ST_FRM        0
`define SPA_ST_ROV        1
`define SPA_ST_TUR        2
`define SPA_ST_HALT       8
`define SPA_ST_RXAV       9
`define SPA_ST_TXFULL     10
`define SPA_FLAGS_RST     3'h0
`define SPA_MASK_RST      3'h0

// bus responses
`define SPA_RESP_OKAY     2'b00
`define SPA_RESP_SLVERR   2'b10

`endif

/* spa_pkg.sv */
// types shared by the audio serial port files
package spa_pkg;

   // shifter states, one-hot
   typedef enum logic [2:0]
   {
      ST_IDLE  = 3'b001,
      ST_SHIFT = 3'b010,
      ST_HALT  = 3'b100
   } spa_state_t;

   // audio framing selections
   typedef enum logic [1:0]
   {
      FRM_I2S = 2'b00,
      FRM_LJ  = 2'b01,
      FRM_RJ  = 2'b10,
      FRM_PCM = 2'b11
   } spa_frame_t;

endpackage

/* spa_port.sv */
// audio serial port with error control and axi4-lite registers
//
// Summary of operation
// - sign extend read rx words when set
// - frame error raises error event only enabled
// - rx overflow raises error event only enabled
// - tx underrun raises error event only enabled
// - tolerated overflow keeps stored rx words
// - critical overflow halts the port
// - tolerated underrun shifts zeros until data, mono right slots resend the last word
// - critical underrun halts the port
// - audio enable selects audio codec framing
// - mono sends each word on both channels
// - framing field picks pcm, rj, lj, i2s
// - audio fields writable only while port off
// - mono and framing ignored without audio
// - unimplemented bits read zero, ignore writes
//
// The register addresses and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
`include "spa_map.svh"
module spa_port
#(
   parameter int WORD_W     = 16,
   parameter int FIFO_DEPTH = 4,
   parameter int ADDR_W     = 8
)
(
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic      [1:0]        s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic      [31:0]       s_axi_rdata,
   output logic      [1:0]        s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic              link_sck,
   input  wire logic              link_ws,
   input  wire logic              link_sdi,
   output logic                   link_sdo,
   output logic                   err_event,
   output logic                   irq
);
   import spa_pkg::*;

   localparam int CW = $clog2(WORD_W + 1);

   logic              sck_q1, sck_q2, sck_q3;
   logic              ws_q1, ws_s, sdi_q1, sdi_s;
   logic              sck_rise;
   logic [31:0]       ctrl_r, con2_r;
   logic [2:0]        flags_r, mask_r, flag_set, flag_clr, err_en;
   logic [WORD_W-1:0] txb_r;
   logic              txb_full_r;
   logic              port_on, aud_en, mono_eff;
   spa_frame_t        mode_eff;
   logic              aw_hold_r, w_hold_r, wr_go;
   logic [ADDR_W-1:0] aw_addr_r;
   logic [31:0]       w_data_r, wr_val;
   logic [3:0]        w_strb_r;
   logic              rd_go, rd_ok;
   logic [31:0]       rd_val;
   spa_state_t        st_r;
   logic [CW-1:0]     bit_r;
   logic              chan_r, pend_r, ws_prev_r, tx_ld_r;
   logic [WORD_W-1:0] rx_sh_r, tx_sh_r, mono_r, rx_in;
   logic              ws_edge, start, start_chan;
   logic              word_done, need_tx, preload, tx_take;
   logic              overflow, underrun, frame_err;
   logic              fifo_ready, fifo_valid, fifo_pop;
   logic [WORD_W-1:0] fifo_data;

   // true when an address hits a register word
   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [7:0] o);
      hit = ({a[ADDR_W-1:2], 2'b00} == ADDR_W'(o));
   endfunction

   // any implemented register
   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      mapped = hit(a, `SPA_OFS_CTRL) | hit(a, `SPA_OFS_CON2) |
               hit(a, `SPA_OFS_STAT) | hit(a, `SPA_OFS_MASK) |
               hit(a, `SPA_OFS_TXB)  | hit(a, `SPA_OFS_RXB);
   endfunction

   // byte-lane merge of write data into a register
   function automatic logic [31:0] wmerge(input logic [31:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  s);
      logic [31:0] m;
      m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      wmerge = (old & ~m) | (d & m);
   endfunction

   // receive word widened to the bus
   function automatic logic [31:0] rx_word(input logic [WORD_W-1:0] d,
                                           input logic sx);
      rx_word = sx ? {{(32-WORD_W){d[WORD_W-1]}}, d}
                   : {{(32-WORD_W){1'b0}}, d};
   endfunction

   // link pins pass two flops before use
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         {sck_q1, sck_q2, sck_q3} <= 3'h0;
         {ws_q1, ws_s, sdi_q1, sdi_s} <= 4'h0;
      end
      else
      begin
         sck_q1 <= link_sck;
         sck_q2 <= sck_q1;
         sck_q3 <= sck_q2;
         ws_q1  <= link_ws;
         ws_s   <= ws_q1;
         sdi_q1 <= link_sdi;
         sdi_s  <= sdi_q1;
      end
   end

   assign sck_rise = sck_q2 & ~sck_q3;

   // effective settings, audio fields only count with audio on
   assign port_on  = ctrl_r[`SPA_ON_BIT];
   assign aud_en   = con2_r[`SPA_AUDIO_PROTOCOL_EN_BIT];
   assign mono_eff = aud_en & con2_r[`SPA_MONO_BIT];
   assign mode_eff = aud_en ? spa_frame_t'(con2_r[`SPA_MOD_HI:`SPA_MOD_LO])
                            : FRM_I2S;

   // write channel: address and data latched in either order
   assign s_axi_awready = ~aw_hold_r & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_hold_r & ~s_axi_bvalid;
   assign wr_go         = aw_hold_r & w_hold_r & ~s_axi_bvalid;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         aw_hold_r    <= 1'b0;
         w_hold_r     <= 1'b0;
         aw_addr_r    <= '0;
         w_data_r     <= 32'h0;
         w_strb_r     <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `SPA_RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid & s_axi_awready)
         begin
            aw_hold_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid & s_axi_wready)
         begin
            w_hold_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         if (wr_go)
         begin
            aw_hold_r    <= 1'b0;
            w_hold_r     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mapped(aw_addr_r) ? `SPA_RESP_OKAY
                                              : `SPA_RESP_SLVERR;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // control registers, audio fields frozen while the port is on
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl_r <= `SPA_CTRL_RST;
         con2_r <= `SPA_CON2_RST;
         mask_r <= `SPA_MASK_RST;
      end
      else if (wr_go)
      begin
         if (hit(aw_addr_r, `SPA_OFS_CTRL))
            ctrl_r <= wmerge(ctrl_r, w_data_r, w_strb_r) & `SPA_CTRL_WMASK;
         if (hit(aw_addr_r, `SPA_OFS_CON2))
            con2_r <= (con2_r & ~wr_val) |
                      (wmerge(con2_r, w_data_r, w_strb_r) & wr_val);
         if (hit(aw_addr_r, `SPA_OFS_MASK))
            mask_r <= w_strb_r[0] ? w_data_r[2:0] : mask_r;
      end
   end

   // writable bits of the second control register
   assign wr_val = port_on ? (`SPA_CON2_WMASK & ~`SPA_CON2_AUDMASK)
                           : `SPA_CON2_WMASK;

   // error flags: sticky, write one to clear, a new event wins
   assign flag_set = {underrun, overflow, frame_err};
   assign flag_clr = (wr_go & hit(aw_addr_r, `SPA_OFS_STAT) & w_strb_r[0])
                     ? w_data_r[2:0] : 3'h0;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         flags_r <= `SPA_FLAGS_RST;
      else
         flags_r <= (flags_r & ~flag_clr) | flag_set;
   end

   // enabled flags merge into one error event, those also set in mask_r into the interrupt
   assign err_en = {con2_r[`SPA_TUREN_BIT], con2_r[`SPA_ROVEN_BIT],
                    con2_r[`SPA_FRMEN_BIT]};
   assign err_event = |(flags_r & err_en);
   assign irq       = |(flags_r & err_en & mask_r);

   // transmit holding buffer, writes while full are dropped
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         txb_r      <= '0;
         txb_full_r <= 1'b0;
      end
      else if (!port_on)
         txb_full_r <= 1'b0;
      else if (tx_take)
         txb_full_r <= 1'b0;
      else if (wr_go & hit(aw_addr_r, `SPA_OFS_TXB) & ~txb_full_r)
      begin
         txb_r      <= w_data_r[WORD_W-1:0];
         txb_full_r <= 1'b1;
      end
   end

   // read channel: one cycle answer, rx reads pop the queue
   assign s_axi_arready = ~s_axi_rvalid;
   assign rd_go         = s_axi_arvalid & s_axi_arready;
   assign fifo_pop      = rd_go & hit(s_axi_araddr, `SPA_OFS_RXB);

   always_comb
   begin
      rd_val = 32'h0;
      rd_ok  = mapped(s_axi_araddr);
      if (hit(s_axi_araddr, `SPA_OFS_CTRL))
         rd_val = ctrl_r;
      if (hit(s_axi_araddr, `SPA_OFS_CON2))
         rd_val = con2_r & `SPA_CON2_WMASK;
      if (hit(s_axi_araddr, `SPA_OFS_STAT))
      begin
         rd_val[2:0]            = flags_r;
         rd_val[`SPA_ST_HALT]   = (st_r == ST_HALT);
         rd_val[`SPA_ST_RXAV]   = fifo_valid;
         rd_val[`SPA_ST_TXFULL] = txb_full_r;
      end
      if (hit(s_axi_araddr, `SPA_OFS_MASK))
         rd_val[2:0] = mask_r;
      if (hit(s_axi_araddr, `SPA_OFS_RXB) & fifo_valid)
         rd_val = rx_word(fifo_data, con2_r[`SPA_SGNEXT_BIT]);
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= `SPA_RESP_OKAY;
      end
      else if (rd_go)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_val;
         s_axi_rresp  <= rd_ok ? `SPA_RESP_OKAY : `SPA_RESP_SLVERR;
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   // frame start per framing selection
   assign ws_edge = ws_s ^ ws_prev_r;
   always_comb
   begin
      start      = 1'b0;
      start_chan = 1'b0;
      if (!aud_en)
         start = ws_s & ~ws_prev_r;
      else
         case (mode_eff)
            FRM_I2S:
            begin
               start      = pend_r;                   // one bit late
               start_chan = ws_s;                     // low is left
            end
            FRM_LJ, FRM_RJ:
            begin
               start      = ws_edge;
               start_chan = ~ws_s;                    // high is left
            end
            FRM_PCM:
               start = ws_s & ~ws_prev_r;             // pulse opens left
            default:
               start = 1'b0;
         endcase
      start = start & sck_rise & port_on;
   end

   // word boundary events
   assign rx_in     = {rx_sh_r[WORD_W-2:0], sdi_s};
   assign word_done = sck_rise & ~start & (st_r == ST_SHIFT) &
                      (bit_r == CW'(WORD_W - 1)) & port_on;
   assign frame_err = start & (st_r == ST_SHIFT) & (bit_r != '0);
   assign overflow  = word_done & ~fifo_ready;
   assign need_tx   = word_done & ~(mono_eff & ~chan_r);
   assign underrun  = need_tx & ~txb_full_r;
   assign preload   = (st_r == ST_IDLE) & port_on & ~tx_ld_r &
                      txb_full_r & ~sck_rise;
   assign tx_take   = (need_tx | preload) & txb_full_r;

   // frame line history on the link clock rises
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ws_prev_r <= 1'b0;
         pend_r    <= 1'b0;
      end
      else if (sck_rise)
      begin
         ws_prev_r <= ws_s;
         pend_r    <= aud_en & (mode_eff == FRM_I2S) & ws_edge;
      end
   end

   // shifter: msb first, sample and advance on each link rise
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_r    <= ST_IDLE;
         bit_r   <= '0;
         chan_r  <= 1'b0;
         tx_ld_r <= 1'b0;
         rx_sh_r <= '0;
         tx_sh_r <= '0;
         mono_r  <= '0;
      end
      else if (!port_on)
      begin
         st_r    <= ST_IDLE;
         bit_r   <= '0;
         chan_r  <= 1'b0;
         tx_ld_r <= 1'b0;
         tx_sh_r <= '0;
      end
      else
         case (st_r)
            ST_HALT:
               tx_sh_r <= '0;
            ST_IDLE, ST_SHIFT:
            begin
               if (preload)
               begin
                  tx_sh_r <= txb_r;
                  mono_r  <= txb_r;
                  tx_ld_r <= 1'b1;
               end
               if (start)
               begin
                  rx_sh_r <= rx_in;
                  tx_sh_r <= tx_sh_r << 1;
                  bit_r   <= CW'(1);
                  chan_r  <= start_chan;
                  st_r    <= ST_SHIFT;
               end
               else if (sck_rise & (st_r == ST_SHIFT))
               begin
                  rx_sh_r <= rx_in;
                  tx_sh_r <= tx_sh_r << 1;
                  bit_r   <= bit_r + 1'b1;
                  if (word_done)
                  begin
                     bit_r <= '0;
                     if (overflow & ~con2_r[`SPA_OVERFLOW_NONCRITICAL_BIT])
                        st_r <= ST_HALT;
                     else if (underrun & ~con2_r[`SPA_UNDERRUN_NONCRITICAL_BIT])
                        st_r <= ST_HALT;
                     else if (aud_en & (mode_eff == FRM_PCM) & ~chan_r)
                        chan_r <= 1'b1;
                     else
                        st_r <= ST_IDLE;
                     if (~need_tx)
                        tx_sh_r <= mono_r;
                     else if (txb_full_r)
                     begin
                        tx_sh_r <= txb_r;
                        mono_r  <= txb_r;
                        tx_ld_r <= 1'b1;
                     end
                     else
                     begin
                        tx_sh_r <= '0;
                        tx_ld_r <= 1'b0;
                     end
                  end
               end
            end
            default:
               st_r <= ST_IDLE;
         endcase
   end

   assign link_sdo = tx_sh_r[WORD_W-1];

   // received words queue; a full queue refuses the new word
   spa_rx_fifo #(
      .WIDTH (WORD_W),
      .DEPTH (FIFO_DEPTH)
   ) u_rx_fifo (
      .clk       (clk),
      .rst_n     (rst_n),
      .clr       (~port_on),
      .in_valid  (word_done),
      .in_data   (rx_in),
      .in_ready  (fifo_ready),
      .out_valid (fifo_valid),
      .out_data  (fifo_data),
      .out_ready (fifo_pop)
   );

endmodule // spa_port

/* spa_port_asserts.sv */
// assertions on the audio serial port bus and event outputs
`timescale 1ns/1ps
`include "spa_map.svh"
module spa_port_asserts
#(
   parameter int ADDR_W = 8
)
(
   input wire logic              clk,
   input wire logic              rst_n,
   input wire logic              s_axi_awvalid,
   input wire logic              s_axi_awready,
   input wire logic              s_axi_wvalid,
   input wire logic              s_axi_wready,
   input wire logic              s_axi_bvalid,
   input wire logic              s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic              s_axi_arvalid,
   input wire logic              s_axi_arready,
   input wire logic [31:0]       s_axi_rdata,
   input wire logic              s_axi_rvalid,
   input wire logic              s_axi_rready,
   input wire logic              err_event,
   input wire logic              irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // bus answers stand until taken
   a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write answer dropped early");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer changed early");
   // no new requests while an answer waits
   a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted during answer");
   a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted during answer");
   // answers follow the handshakes
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready
      && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write answer late");
   // unimplemented control bits read zero
   a_con2_zeros: assert property (
      s_axi_arvalid && s_axi_arready && s_axi_araddr == `SPA_OFS_CON2
      |=> (s_axi_rdata & 32'hffff_6074) == 32'h0)
      else $error("unimplemented bits nonzero");
   // interrupt only from a raised event
   a_irq_gated: assert property (irq |-> err_event)
      else $error("irq without event");
endmodule // spa_port_asserts

bind spa_port spa_port_asserts #(.ADDR_W(ADDR_W)) u_asserts (.clk, .rst_n,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
   .err_event, .irq);

/* spa_rx_fifo.sv */
// receive word queue held in flip-flops
`timescale 1ns/1ps
module spa_rx_fifo
#(
   parameter int WIDTH = 16,
   parameter int DEPTH = 4
)
(
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             clr,
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  in_ready,
   output logic                  out_valid,
   output logic      [WIDTH-1:0] out_data,
   input  wire logic             out_ready
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wr_r;
   logic [AW-1:0]    rd_r;
   logic [AW:0]      cnt_r;
   logic             push;
   logic             pop;

   // advance an index with wrap
   function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
      step = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   // full refuses, so stored words are never overwritten
   assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign out_data  = mem_r[rd_r];
   assign push      = in_valid & in_ready;
   assign pop       = out_ready & out_valid;

   // pointers and fill count
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_r  <= '0;
         rd_r  <= '0;
         cnt_r <= '0;
      end
      else if (clr)
      begin
         wr_r  <= '0;
         rd_r  <= '0;
         cnt_r <= '0;
      end
      else
      begin
         if (push)
            wr_r <= step(wr_r);
         if (pop)
            rd_r <= step(rd_r);
         if (push & ~pop)
            cnt_r <= cnt_r + 1'b1;
         else if (pop & ~push)
            cnt_r <= cnt_r - 1'b1;
      end
   end

   // word storage
   always_ff @(posedge clk)
   begin
      if (push & ~clr)
         mem_r[wr_r] <= in_data;
   end

endmodule // spa_rx_fifo

/* testbench.sv */
// self-checking bench for the audio serial port
`timescale 1ns/1ps
`include "spa_map.svh"
module testbench;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  s_axi_awaddr;
   logic [7:0]  s_axi_araddr;
   logic [31:0] s_axi_wdata;
   logic [3:0]  s_axi_wstrb;
   logic        s_axi_awvalid;
   logic        s_axi_wvalid;
   logic        s_axi_bready;
   logic        s_axi_arvalid;
   logic        s_axi_rready;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
   logic [31:0] s_axi_rdata, rd;
   logic        link_sck, link_ws, link_sdi, link_sdo, err_event, irq;
   int          mismatches = 0;
   int          n_tests = 0;
   int          cyc = 0;

   spa_port #(.WORD_W(16), .FIFO_DEPTH(4), .ADDR_W(8)) uut (.clk, .rst_n,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .link_sck, .link_ws, .link_sdi, .link_sdo,
      .err_event, .irq);
   spa_codec codec (.link_sck, .link_ws, .link_sdi, .link_sdo);

   // 20 MHz clock
   always #25 clk = ~clk;
   // cycle ceiling against hangs
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         mismatches++;
         give_verdict;
      end
   end

   task give_verdict;
      if (mismatches == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // axi write: hold each channel until its own ready
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bit da, dw, db;
      int t;
      db = 1'b0;
      t = 0;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!db && t < 40)
      begin
         @(negedge clk);
         da = s_axi_awvalid && s_axi_awready;
         dw = s_axi_wvalid && s_axi_wready;
         db = s_axi_bvalid;
         rsp = s_axi_bresp;
         @(posedge clk);
         if (da) s_axi_awvalid <= 1'b0;
         if (dw) s_axi_wvalid <= 1'b0;
         if (db) s_axi_bready <= 1'b0;
         t++;
      end
      if (!db) mismatches++;
   endtask

   // axi read into rd and rsp
   task automatic rd_reg(input logic [7:0] a);
      bit ha, hr;
      int t;
      hr = 1'b0;
      t = 0;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!hr && t < 40)
      begin
         @(negedge clk);
         ha = s_axi_arvalid && s_axi_arready;
         hr = s_axi_rvalid;
         rd = s_axi_rdata;
         rsp = s_axi_rresp;
         @(posedge clk);
         if (ha) s_axi_arvalid <= 1'b0;
         if (hr) s_axi_rready <= 1'b0;
         t++;
      end
      if (!hr) mismatches++;
   endtask

   task automatic chk(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
      rd_reg(a);
      cmp(rd & m, e);
   endtask

   task automatic pins(input logic [31:0] e);
      @(negedge clk);
      cmp({30'h0, irq, err_event}, e);
   endtask

   // reset value, unused bits, unmapped place, lock while on
   task t_regs;
      chk(`SPA_OFS_CON2, 32'hffffffff, 32'h0);
      wr(`SPA_OFS_CON2, 32'hffffffff);
      chk(`SPA_OFS_CON2, 32'hffffffff, 32'h9f8b);
      rd_reg(8'h40);
      cmp({30'h0, rsp}, {30'h0, `SPA_RESP_SLVERR});
      wr(`SPA_OFS_CTRL, 32'h8000);
      wr(`SPA_OFS_CON2, 32'h0);
      chk(`SPA_OFS_CON2, 32'hffffffff, 32'h008b);
      wr(`SPA_OFS_CTRL, 32'h0);
      wr(`SPA_OFS_CON2, 32'h0);
      chk(`SPA_OFS_CON2, 32'hffffffff, 32'h0);
      s_axi_wstrb <= 4'h1;
      wr(`SPA_OFS_CON2, 32'hffffffff);
      s_axi_wstrb <= 4'hf;
      chk(`SPA_OFS_CON2, 32'hffffffff, 32'h008b);
   endtask

   // tolerated underrun and overflow, sign extension, interrupt
   task t_link;
      wr(`SPA_OFS_CON2, 32'h8f00);
      wr(`SPA_OFS_CTRL, 32'h8000);
      wr(`SPA_OFS_TXB, 32'ha5c3);
      codec.xfer(16'h8001);
      cmp({16'h0, codec.rx_word}, 32'ha5c3);
      codec.xfer(16'h0002);
      cmp({16'h0, codec.rx_word}, 32'h0);
      codec.xfer(16'h0003);
      codec.xfer(16'h0004);
      codec.xfer(16'h7fff);
      repeat (10) @(posedge clk);
      chk(`SPA_OFS_STAT, 32'h107, 32'h006);
      pins(32'h1);
      wr(`SPA_OFS_MASK, 32'h2);
      pins(32'h3);
      chk(`SPA_OFS_RXB, 32'hffffffff, 32'hffff8001);
      for (int i = 2; i < 5; i++)
         chk(`SPA_OFS_RXB, 32'hffffffff, i);
      chk(`SPA_OFS_RXB, 32'hffffffff, 32'h0);
      wr(`SPA_OFS_STAT, 32'h7);
      pins(32'h0);
      wr(`SPA_OFS_CON2, 32'h9300);
      codec.xfer(16'h0, 4);
      codec.xfer(16'h0);
      repeat (10) @(posedge clk);
      chk(`SPA_OFS_STAT, 32'h7, 32'h5);
      pins(32'h1);
      wr(`SPA_OFS_STAT, 32'h7);
   endtask

   // critical underrun halts, event withheld while disabled
   task t_halt;
      wr(`SPA_OFS_CTRL, 32'h0);
      wr(`SPA_OFS_CON2, 32'h0);
      wr(`SPA_OFS_CTRL, 32'h8000);
      codec.xfer(16'h0, 4);
      codec.xfer(16'h9234);
      repeat (10) @(posedge clk);
      chk(`SPA_OFS_STAT, 32'h107, 32'h105);
      pins(32'h0);
      chk(`SPA_OFS_RXB, 32'hffffffff, 32'h9234);
   endtask

   // pcm mono: one buffered word goes out on both channels
   task t_audio;
      wr(`SPA_OFS_CTRL, 32'h0);
      wr(`SPA_OFS_CON2, 32'h038b);
      wr(`SPA_OFS_CTRL, 32'h8000);
      wr(`SPA_OFS_TXB, 32'h3c5a);
      codec.xfer(16'h0);
      cmp({16'h0, codec.rx_word}, 32'h3c5a);
      codec.xfer(16'h0);
      cmp({16'h0, codec.rx_word}, 32'h3c5a);
   endtask

   // main sequence
   initial
   begin
      s_axi_awaddr <= 8'h00;
      s_axi_araddr <= 8'h00;
      s_axi_wdata <= 32'h0;
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      s_axi_bready <= 1'b0;
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      t_regs;
      t_link;
      t_halt;
      t_audio;
      give_verdict;
   end
endmodule // testbench
